// ---- wfm_pkg.sv ----
package wfm_pkg;

   // ==========================================================
   // register map (byte addresses, one word each)
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;

   // ==========================================================
   // control register fields
   localparam int CTRL_CLR_BIT = 0;

   // ==========================================================
   // status register fields
   localparam int ST_WR_UNREADY = 0;
   localparam int ST_OVERLAP    = 1;
   localparam int ST_NO_AC      = 2;
   localparam int ST_MULTI_HEAD = 3;
   localparam int ST_DRV_FAULT  = 4;
   localparam int ST_INTERLOCK  = 5;
   localparam int ST_DRV_READY  = 6;
   localparam int ST_UNLOADING  = 7;
   localparam int ST_SUPPLY     = 8;

   // ==========================================================
   // interrupt events, same layout in status and mask
   localparam int EV_W          = 6;
   localparam int EV_WR_UNREADY = 0;
   localparam int EV_OVERLAP    = 1;
   localparam int EV_NO_AC      = 2;
   localparam int EV_MULTI_HEAD = 3;
   localparam int EV_INTERLOCK  = 4;
   localparam int EV_RETRACTED  = 5;
   localparam logic [EV_W-1:0] IRQ_MASK_RST = 6'h00;

   // ==========================================================
   // types
   typedef struct packed {
      logic writeUnready;
      logic overlap;
      logic noAc;
      logic multiHead;
   } wfm_latch_t;

   localparam wfm_latch_t LATCH_RST = 4'h0;

   typedef enum logic [1:0] {
      UNL_IDLE,
      UNL_RETRACT,
      UNL_STOP,
      UNL_HOLD
   } wfm_unload_t;

endpackage

// ---- wfm_top.sv ----
// Function
// - general interlock fault: output low, indicator on, unload, brake, unlock door.
// - supply or spindle-board interlock: output low, indicator on, unload, no brake or unlock; supply lamp off for a supply fault only.
// - watch two soft and three destructive read/write fault conditions.
// - latch write-unready when writing, heads unsettled and no other fault.
// - write-unready latch drives its output, soft, combined, lamp and status bit 4.
// - soft latches clear on power-on start, run switch or clear-status command.
// - latch overlap when read gate rises during write with no other fault.
// - overlap latch drives its output, soft, combined, lamp and status bit 4.
// - any latched read/write fault holds combined fault low, blocking all later read/write faults; the interlock still latches.
// - latch no-AC when AC current absent during write with no fault.
// - destructive fault drives its signal low and starts unload, no spindle brake.
// - destructive latches clear only on power-on start or run switch.
// - latch multi-head when multi-head select low and no other fault.
// - DC current without write mode sets both no-AC and multi-head latches.
// - unload lights lamp, status 4, retracts, drops ready and servo, ends retracted.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module wfm_top #(
   parameter int ADDR_W = 12
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              write_mode,
   input  wire logic              heads_unsettled,
   input  wire logic              read_gate_active,
   input  wire logic              ac_write_current,
   input  wire logic              multi_head_select_n,
   input  wire logic              dc_write_current,
   input  wire logic              power_on_seq_start,
   input  wire logic              run_switch_run,
   input  wire logic              clear_status_cmd,
   input  wire logic              interlock_fault,
   input  wire logic              logic_supply_good,
   input  wire logic              spindle_board_present,
   input  wire logic              heads_retracted,
   output logic                   write_unready_fault_out_n,
   output logic                   overlap_fault_out_n,
   output logic                   no_ac_fault_out_n,
   output logic                   multi_head_fault_out_n,
   output logic                   any_write_fault_n,
   output logic                   nondestructive_fault_n,
   output logic                   destructive_fault_n,
   output logic                   interlock_fault_out_n,
   output logic                   drive_fault_lamp_n,
   output logic                   supply_lamp,
   output logic                   retract_request,
   output logic                   drive_ready,
   output logic                   servo_enable,
   output logic                   spindle_brake,
   output logic                   door_unlock,
   output logic                   irq
);

   // ==========================================================
   // declarations
   wfm_pkg::wfm_latch_t  latch_q;
   wfm_pkg::wfm_latch_t  latch_d;
   wfm_pkg::wfm_unload_t unlState_q;
   wfm_pkg::wfm_unload_t unlState_d;
   logic                 readGatePrev_q;
   logic                 ilLatch_q;
   logic                 ilLatch_d;
   logic                 fullSeq_q;
   logic                 fullSeq_d;
   logic                 regClr_q;
   logic                 softClr;
   logic                 hardClr;
   logic                 noFault;
   logic                 setWar;
   logic                 setOverlap;
   logic                 setNoAc;
   logic                 setMulti;
   logic                 setDc;
   logic                 ilPartial;
   logic                 unloadReq;
   logic [wfm_pkg::EV_W-1:0] irqStat_q;
   logic [wfm_pkg::EV_W-1:0] irqStat_d;
   logic [wfm_pkg::EV_W-1:0] irqMask_q;
   logic [wfm_pkg::EV_W-1:0] events;
   logic [31:0]          statusWord;
   logic                 apbSetup;
   logic                 apbDone;
   logic                 hitCtrl;
   logic                 hitStatus;
   logic                 hitIrqStat;
   logic                 hitIrqMask;

   // ==========================================================
   // clear pulses
   // a register write is turned into a one-cycle command, like the decoded pin
   assign hardClr = power_on_seq_start | run_switch_run;
   assign softClr = hardClr | clear_status_cmd | regClr_q;

   // ==========================================================
   // fault set conditions
   assign noFault    = (latch_q == wfm_pkg::LATCH_RST);
   assign setWar     = write_mode & heads_unsettled & noFault;
   assign setOverlap = write_mode & read_gate_active & ~readGatePrev_q
                       & noFault;
   assign setNoAc    = write_mode & ~ac_write_current & noFault;
   assign setMulti   = ~multi_head_select_n & noFault;
   assign setDc      = dc_write_current & ~write_mode & noFault;

   // clear sits outside the set so it always wins
   always_comb begin
      latch_d = latch_q;
      latch_d.writeUnready = softClr ? 1'b0 : (latch_q.writeUnready | setWar);
      latch_d.overlap      = softClr ? 1'b0 : (latch_q.overlap | setOverlap);
      latch_d.noAc         = hardClr ? 1'b0 : (latch_q.noAc | setNoAc | setDc);
      latch_d.multiHead    = hardClr ? 1'b0 : (latch_q.multiHead | setMulti | setDc);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         latch_q        <= wfm_pkg::LATCH_RST;
         readGatePrev_q <= 1'b0;
      end else begin
         latch_q        <= latch_d;
         readGatePrev_q <= read_gate_active;
      end
   end

   // ==========================================================
   // interlock latch
   assign ilPartial = ~logic_supply_good | ~spindle_board_present;
   assign ilLatch_d = hardClr ? 1'b0 : (ilLatch_q | interlock_fault);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ilLatch_q <= 1'b0;
      end else begin
         ilLatch_q <= ilLatch_d;
      end
   end

   // ==========================================================
   // head unload sequencer
   // destructive faults never ask for the spindle stop; only a full interlock does
   assign unloadReq = latch_d.noAc | latch_d.multiHead | ilLatch_d;

   always_comb begin
      unlState_d = unlState_q;
      fullSeq_d  = fullSeq_q;
      if (hardClr) begin
         unlState_d = wfm_pkg::UNL_IDLE;
         fullSeq_d  = 1'b0;
      end else begin
         if (interlock_fault && !ilPartial) begin
            fullSeq_d = 1'b1;
         end
         unique case (unlState_q)
            wfm_pkg::UNL_IDLE: begin
               if (unloadReq) begin
                  unlState_d = wfm_pkg::UNL_RETRACT;
               end
            end
            wfm_pkg::UNL_RETRACT: begin
               if (heads_retracted) begin
                  unlState_d = fullSeq_d ? wfm_pkg::UNL_STOP : wfm_pkg::UNL_HOLD;
               end
            end
            wfm_pkg::UNL_STOP: begin
               unlState_d = wfm_pkg::UNL_STOP;
            end
            wfm_pkg::UNL_HOLD: begin
               if (fullSeq_d) begin
                  unlState_d = wfm_pkg::UNL_STOP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         unlState_q <= wfm_pkg::UNL_IDLE;
         fullSeq_q  <= 1'b0;
      end else begin
         unlState_q <= unlState_d;
         fullSeq_q  <= fullSeq_d;
      end
   end

   // ==========================================================
   // registered outputs, taken from next-state so they track the latches
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         write_unready_fault_out_n <= 1'b1;
         overlap_fault_out_n       <= 1'b1;
         no_ac_fault_out_n         <= 1'b1;
         multi_head_fault_out_n    <= 1'b1;
         any_write_fault_n         <= 1'b1;
         nondestructive_fault_n    <= 1'b1;
         destructive_fault_n       <= 1'b1;
         interlock_fault_out_n     <= 1'b1;
         drive_fault_lamp_n        <= 1'b1;
         supply_lamp               <= 1'b0;
         retract_request           <= 1'b0;
         spindle_brake             <= 1'b0;
         door_unlock               <= 1'b0;
      end else begin
         write_unready_fault_out_n <= ~latch_d.writeUnready;
         overlap_fault_out_n       <= ~latch_d.overlap;
         no_ac_fault_out_n         <= ~latch_d.noAc;
         multi_head_fault_out_n    <= ~latch_d.multiHead;
         any_write_fault_n         <= (latch_d == wfm_pkg::LATCH_RST);
         nondestructive_fault_n    <= ~(latch_d.writeUnready | latch_d.overlap);
         destructive_fault_n       <= ~(latch_d.noAc | latch_d.multiHead);
         interlock_fault_out_n     <= ~ilLatch_d;
         drive_fault_lamp_n        <= (latch_d == wfm_pkg::LATCH_RST) & ~ilLatch_d
                                      & (unlState_d == wfm_pkg::UNL_IDLE);
         supply_lamp               <= logic_supply_good;
         retract_request           <= (unlState_d == wfm_pkg::UNL_RETRACT);
         spindle_brake             <= (unlState_d == wfm_pkg::UNL_STOP);
         door_unlock               <= (unlState_d == wfm_pkg::UNL_STOP);
      end
   end

   // ready and servo drop on unload start, come back with a hard clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         drive_ready  <= 1'b0;
         servo_enable <= 1'b0;
      end else if (hardClr) begin
         drive_ready  <= 1'b1;
         servo_enable <= 1'b1;
      end else if (unlState_d != wfm_pkg::UNL_IDLE) begin
         drive_ready  <= 1'b0;
         servo_enable <= 1'b0;
      end
   end

   // ==========================================================
   // status word
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[wfm_pkg::ST_WR_UNREADY] = latch_q.writeUnready;
      statusWord[wfm_pkg::ST_OVERLAP]    = latch_q.overlap;
      statusWord[wfm_pkg::ST_NO_AC]      = latch_q.noAc;
      statusWord[wfm_pkg::ST_MULTI_HEAD] = latch_q.multiHead;
      statusWord[wfm_pkg::ST_DRV_FAULT]  = ~drive_fault_lamp_n;
      statusWord[wfm_pkg::ST_INTERLOCK]  = ilLatch_q;
      statusWord[wfm_pkg::ST_DRV_READY]  = drive_ready;
      statusWord[wfm_pkg::ST_UNLOADING]  = (unlState_q != wfm_pkg::UNL_IDLE);
      statusWord[wfm_pkg::ST_SUPPLY]     = supply_lamp;
   end

   // ==========================================================
   // apb slave: no wait state, data latched in setup
   assign apbSetup   = psel & ~penable & ~pready;
   assign apbDone    = psel & penable & pready;
   assign hitCtrl    = (paddr == wfm_pkg::OFS_CTRL);
   assign hitStatus  = (paddr == wfm_pkg::OFS_STATUS);
   assign hitIrqStat = (paddr == wfm_pkg::OFS_IRQ_STAT);
   assign hitIrqMask = (paddr == wfm_pkg::OFS_IRQ_MASK);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apbSetup;
         pslverr <= apbSetup & ~(hitCtrl | hitStatus | hitIrqStat | hitIrqMask);
         if (apbSetup && !pwrite) begin
            unique case (1'b1)
               hitStatus:  prdata <= statusWord;
               hitIrqStat: prdata <= {{(32-wfm_pkg::EV_W){1'b0}}, irqStat_q};
               hitIrqMask: prdata <= {{(32-wfm_pkg::EV_W){1'b0}}, irqMask_q};
               default:    prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regClr_q  <= 1'b0;
         irqMask_q <= wfm_pkg::IRQ_MASK_RST;
      end else begin
         regClr_q <= apbDone & pwrite & hitCtrl & pwdata[wfm_pkg::CTRL_CLR_BIT];
         if (apbDone && pwrite && hitIrqMask) begin
            irqMask_q <= pwdata[wfm_pkg::EV_W-1:0];
         end
      end
   end

   // ==========================================================
   // interrupts; a new event beats the read-clear
   always_comb begin
      events = '0;
      events[wfm_pkg::EV_WR_UNREADY] = latch_d.writeUnready & ~latch_q.writeUnready;
      events[wfm_pkg::EV_OVERLAP]    = latch_d.overlap & ~latch_q.overlap;
      events[wfm_pkg::EV_NO_AC]      = latch_d.noAc & ~latch_q.noAc;
      events[wfm_pkg::EV_MULTI_HEAD] = latch_d.multiHead & ~latch_q.multiHead;
      events[wfm_pkg::EV_INTERLOCK]  = ilLatch_d & ~ilLatch_q;
      events[wfm_pkg::EV_RETRACTED]  = (unlState_q == wfm_pkg::UNL_RETRACT)
                                       & (unlState_d != wfm_pkg::UNL_RETRACT);
      irqStat_d = irqStat_q;
      if (apbDone && !pwrite && hitIrqStat) begin
         irqStat_d = '0;
      end
      irqStat_d = irqStat_d | events;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irqStat_q <= '0;
         irq       <= 1'b0;
      end else begin
         irqStat_q <= irqStat_d;
         irq       <= |(irqStat_d & ((apbDone && pwrite && hitIrqMask)
                                    ? pwdata[wfm_pkg::EV_W-1:0] : irqMask_q));
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   war_set_a: assert property (setWar && !softClr |=> !write_unready_fault_out_n
      && !nondestructive_fault_n && !any_write_fault_n)
      else $error("write-unready fault not latched");
   overlap_set_a: assert property (write_mode && $rose(read_gate_active) && noFault
      && !softClr |-> ##1 !overlap_fault_out_n)
      else $error("overlap fault not latched");
   fault_block_a: assert property (!noFault && !hardClr && !softClr |=>
      ((latch_q & ~$past(latch_q)) == wfm_pkg::LATCH_RST))
      else $error("later fault set while one held");
   soft_clear_a: assert property (softClr |=> write_unready_fault_out_n
      && overlap_fault_out_n)
      else $error("soft latches survived clear");
   hard_keep_a: assert property (!no_ac_fault_out_n && !hardClr |=> !no_ac_fault_out_n)
      else $error("destructive latch lost without hard clear");
   dc_both_a: assert property (setDc && !hardClr |=> !no_ac_fault_out_n
      && !multi_head_fault_out_n && !destructive_fault_n)
      else $error("dc fault did not set both latches");
   unload_start_a: assert property ($fell(destructive_fault_n) && $past(unlState_q)
      == wfm_pkg::UNL_IDLE |-> retract_request && !drive_ready && !drive_fault_lamp_n)
      else $error("destructive fault did not start unload");
   no_brake_a: assert property (spindle_brake |-> fullSeq_q && door_unlock)
      else $error("spindle braked without full interlock");
   retract_end_a: assert property (retract_request && heads_retracted && !hardClr
      |=> !retract_request)
      else $error("retract did not end when retracted");
   il_out_a: assert property (interlock_fault && !hardClr ##1 !hardClr
      |-> !interlock_fault_out_n [*2])
      else $error("interlock output not held");
   irq_level_a: assert property (irq == |(irqStat_q & irqMask_q))
      else $error("irq out of step with status");

endmodule

// ---- wfm_drive_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// head carriage: retracts a while after the unload request
module wfm_drive_model (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic slow,
   input  wire logic retract_request,
   input  wire logic drive_ready,
   output logic      heads_retracted
);
   logic [3:0] waitQ;

   // heads stay back until a reload, which a ready drive implies
   always_ff @(posedge clk) begin
      if (!reset_n || drive_ready) begin
         waitQ <= 4'h0;
         heads_retracted <= 1'b0;
      end else if (retract_request && !heads_retracted) begin
         if (waitQ >= (slow ? 4'h7 : 4'h2)) begin
            heads_retracted <= 1'b1;
         end else begin
            waitQ <= waitQ + 4'h1;
         end
      end
   end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
   // ==========================================================
   // signals; fault inputs packed as {wm,unsettled,rgate,ac,mhs_n,dc}
   localparam logic [5:0] IDLE = 6'h06;
   logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, slowRet;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        er, write_mode, heads_unsettled, read_gate_active, ac_write_current;
   logic        multi_head_select_n, dc_write_current, power_on_seq_start, run_switch_run;
   logic        clear_status_cmd, interlock_fault, logic_supply_good, spindle_board_present;
   logic        heads_retracted, write_unready_fault_out_n, overlap_fault_out_n;
   logic        no_ac_fault_out_n, multi_head_fault_out_n, any_write_fault_n;
   logic        nondestructive_fault_n, destructive_fault_n, interlock_fault_out_n;
   logic        drive_fault_lamp_n, supply_lamp, retract_request, drive_ready;
   logic        servo_enable, spindle_brake, door_unlock;
   int          miscompares = 0, checkCount = 0, cycles = 0;
   wire  [3:0]  latN = {write_unready_fault_out_n, overlap_fault_out_n,
                         no_ac_fault_out_n, multi_head_fault_out_n};
   wire  [2:0]  sumN = {any_write_fault_n, nondestructive_fault_n, destructive_fault_n};

   wfm_top dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .write_mode, .heads_unsettled, .read_gate_active,
      .ac_write_current, .multi_head_select_n, .dc_write_current, .power_on_seq_start,
      .run_switch_run, .clear_status_cmd, .interlock_fault, .logic_supply_good,
      .spindle_board_present, .heads_retracted, .write_unready_fault_out_n,
      .overlap_fault_out_n, .no_ac_fault_out_n, .multi_head_fault_out_n,
      .any_write_fault_n, .nondestructive_fault_n, .destructive_fault_n,
      .interlock_fault_out_n, .drive_fault_lamp_n, .supply_lamp, .retract_request,
      .drive_ready, .servo_enable, .spindle_brake, .door_unlock, .irq);
   wfm_drive_model model (.clk, .reset_n, .slow(slowRet), .retract_request,
      .drive_ready, .heads_retracted);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // whole run is well under this many cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         end_sim();
      end
   end

   // ==========================================================
   // helpers
   task automatic end_sim;
      if (miscompares == 0 && checkCount > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic go(input logic [5:0] v, input logic [2:0] c);
      @(posedge clk);
      {write_mode, heads_unsettled, read_gate_active, ac_write_current,
       multi_head_select_n, dc_write_current} <= v;
      {power_on_seq_start, run_switch_run, clear_status_cmd} <= c;
   endtask

   // one-cycle clear pulse with the fault inputs quiet
   task automatic pulse(input logic [2:0] c);
      go(IDLE, c);
      go(IDLE, 3'h0);
      cyc(3);
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      chk("pready", pready, 1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_ret;
      int n;
      n = 0;
      while (retract_request !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      cyc(3);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      chk("latN", latN, 4'hf);
      chk("sumN", sumN, 3'h7);
      chk("ready", drive_ready, 0);
      pulse(3'b100);
      chk("ready", {drive_ready, servo_enable}, 2'b11);
      apb(0, 12'h010, 32'h0);
      chk("slverr", er, 1);
      chk("unmapped", rd, 0);
      apb(0, wfm_pkg::OFS_IRQ_MASK, 32'h0);
      chk("maskrst", rd, 32'h0);
   endtask

   task automatic t_soft(input int m);
      apb(1, wfm_pkg::OFS_IRQ_MASK, 32'h1);
      if (m == 0) begin
         go(6'h36, 3'h0);
         cyc(3);
         chk("wru", latN, 4'h7);
         chk("sum", {sumN, drive_fault_lamp_n, retract_request, irq}, 6'h09);
         go(6'h3e, 3'h0);
         cyc(3);
         chk("block", latN, 4'h7);
      end else begin
         go(6'h26, 3'h0);
         go(6'h2e, 3'h0);
         cyc(3);
         chk("ovl", latN, 4'hb);
         chk("sum", {sumN, drive_fault_lamp_n, irq}, 5'h04);
      end
      apb(0, wfm_pkg::OFS_STATUS, 32'h0);
      chk("st", rd[4:0], (m == 0) ? 5'h11 : 5'h12);
      apb(0, wfm_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irqst", rd, 32'h1 << m);
      apb(0, wfm_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irqclr", rd, 0);
      chk("irqoff", irq, 0);
      go(IDLE, 3'h0);
      if (m == 0) apb(1, wfm_pkg::OFS_CTRL, 32'h1);
      else pulse(3'b001);
      cyc(3);
      chk("sclr", {latN, sumN, drive_fault_lamp_n}, 8'hff);
   endtask

   // clear and set in the same cycle: clear must win
   task automatic t_prio;
      go(6'h36, 3'b001);
      go(IDLE, 3'h0);
      cyc(3);
      chk("prio", latN, 4'hf);
   endtask

   task automatic t_dest;
      logic [5:0] v[3] = '{6'h22, 6'h04, 6'h07};
      logic [3:0] e[3] = '{4'hd, 4'he, 4'hc};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         slowRet <= i[0];
         go(v[i], 3'h0);
         cyc(3);
         chk("dlat", latN, e[i]);
         chk("dsum", {sumN, drive_fault_lamp_n, irq}, 5'h08);
         chk("unl", {retract_request, drive_ready, servo_enable}, 3'b100);
         pulse(3'b001);
         chk("noclr", latN, e[i]);
         wait_ret();
         chk("noBrake", {retract_request, spindle_brake, door_unlock}, 3'h0);
         pulse((i == 1) ? 3'b010 : 3'b100);
         chk("hclr", {latN, drive_ready}, 5'h1f);
      end
      apb(0, wfm_pkg::OFS_IRQ_STAT, 32'h0);
      chk("dirq", rd, 32'h2c);
   endtask

   task automatic t_ilk;
      apb(1, wfm_pkg::OFS_IRQ_MASK, 32'h10);
      for (int j = 0; j < 3; j++) begin
         @(posedge clk);
         interlock_fault <= 1'b1;
         logic_supply_good <= (j != 1);
         spindle_board_present <= (j != 2);
         cyc(3);
         chk("ilk", {interlock_fault_out_n, retract_request, irq}, 3'b011);
         wait_ret();
         chk("brake", {spindle_brake, door_unlock}, (j == 0) ? 2'b11 : 2'b00);
         chk("psu", supply_lamp, j != 1);
         apb(0, wfm_pkg::OFS_IRQ_STAT, 32'h0);
         chk("iirq", rd, 32'h30);
         @(posedge clk);
         interlock_fault <= 1'b0;
         logic_supply_good <= 1'b1;
         spindle_board_present <= 1'b1;
         pulse(3'b100);
         chk("iclr", {interlock_fault_out_n, spindle_brake, drive_ready, irq}, 4'ha);
      end
   endtask

   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, slowRet} = '0;
      {write_mode, heads_unsettled, read_gate_active, ac_write_current,
       multi_head_select_n, dc_write_current} = IDLE;
      {power_on_seq_start, run_switch_run, clear_status_cmd, interlock_fault} = '0;
      {logic_supply_good, spindle_board_present} = 2'b11;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      cyc(1);
      t_reset();
      t_soft(0);
      t_soft(1);
      t_prio();
      t_dest();
      t_ilk();
      end_sim();
   end
endmodule
